// >>> rtl/dmbia_addr_gen.v
// Effective address generator for direct and indirect data memory accesses.
`timescale 1ns/1ns
`default_nettype none
`include "dmbia_defs.vh"

module dmbia_addr_gen
(
    // Requested address and pointer state.
    input wire [7:0] reqAddr,
    input wire [7:0] pointerZero,
    input wire [7:0] pointerOne,
    input wire bankSelectBit,
    // Effective address: bank bit prefixed to an 8-bit location.
    output reg [8:0] effAddr,
    output reg viaPort
);

    // Indirect ports are replaced by their pointer; direct goes to bank 0.
    always @*
    begin
        viaPort = 1'b0;
        effAddr = {1'b0, reqAddr};
        if (reqAddr == `DMBIA_ADDR_PORT0)
        begin
            viaPort = 1'b1;
            effAddr = {1'b0, pointerZero};
        end
        else if (reqAddr == `DMBIA_ADDR_PORT1)
        begin
            viaPort = 1'b1;
            effAddr = {bankSelectBit, pointerOne};
        end
    end

endmodule // dmbia_addr_gen
`default_nettype wire

// >>> rtl/dmbia_core.v
// Data memory addressing core: pointers, bank select, work register and RAM decode.
`timescale 1ns/1ns
`default_nettype none
`include "dmbia_defs.vh"

// Summary of operation
// - Indirect ports access location named by pointer.
// - Port zero uses bank 0; port one uses selected bank.
// - Pointer at an indirect port: read 00H, write ignored.
// - Both pointers are plain readable writable 8-bit registers.
// - Direct accesses always go to bank 0.
// - Only bit 0 of bank select chooses bank.
// - Reset clears bank, except watchdog reset while powered down.
// - Addresses 00H-3FH decode identically in both banks.
// - ALU results are written into the work register.
// - Register moves pass through the work register.
// - Indirect effective address is the pointer value, with the bank bit above it on port one.
// - Bank select bit 0 only; bits 7-1 read zero.
// - Address 40H is eeprom control only in bank 1.
module dmbia_core
(
    // Clock, enable and reset.
    input wire sysClk,
    input wire clkEn,
    input wire reset_n,
    // Reset cause: watchdog time-out while in power-down keeps the bank.
    input wire watchdogPowerDownReset,
    // Data memory access from the execution datapath.
    input wire memRd,
    input wire memWr,
    input wire [7:0] memAddr,
    input wire [7:0] memWrData,
    output reg [7:0] memRdData_r,
    // ALU result and work register load.
    input wire aluWr,
    input wire [7:0] aluResult,
    input wire workLoad,
    // External special function registers (06H to 3FH of the shared window).
    input wire [7:0] sfrRdData,
    output reg sfrRd_r,
    output reg sfrWr_r,
    output reg [7:0] sfrAddr_r,
    output reg [7:0] sfrWrData_r,
    // Eeprom control register, reached only in bank 1.
    input wire [7:0] eepromControlRdData,
    output reg eepromControlWr_r,
    output reg [7:0] eepromControlWrData_r,
    // Observed state.
    output reg [7:0] workRegister_r,
    output reg bankSelectBit_r
);

    // Stored pointers, next-state values and write enables.
    reg [7:0] pointerZero_r;
    reg [7:0] pointerOne_r;
    reg [7:0] workRegister_nxt;
    reg [7:0] rdData_nxt;
    reg bankSelectBit_nxt;
    reg [7:0] pointerZero_nxt;
    reg [7:0] pointerOne_nxt;
    reg ramWr;
    reg sfrRd_nxt;
    reg sfrWr_nxt;
    reg eeWr_nxt;
    // Decode of the effective address.
    wire [8:0] effAddr;
    wire viaPort;
    wire [7:0] ramRdData;
    wire [7:0] loc;
    wire bankOne;
    wire isSfr;
    wire isCore;
    wire isGp;
    wire isEeCtl;
    wire portSelf;
    wire [7:0] gpOffset;

    // Resolve the effective address for this access.
    dmbia_addr_gen addrGen
    (
        .reqAddr(memAddr),
        .pointerZero(pointerZero_r),
        .pointerOne(pointerOne_r),
        .bankSelectBit(bankSelectBit_r),
        .effAddr(effAddr),
        .viaPort(viaPort)
    );

    // Location decode; the special function window ignores the bank.
    assign loc = effAddr[7:0];
    assign bankOne = effAddr[8];
    assign isSfr = (loc <= `DMBIA_SFR_LAST);
    assign isCore = (loc <= `DMBIA_ADDR_WORK);
    assign portSelf = viaPort && ((loc == `DMBIA_ADDR_PORT0) || (loc == `DMBIA_ADDR_PORT1));
    assign isEeCtl = bankOne && (loc == `DMBIA_ADDR_EECTL);
    assign isGp = !bankOne && (loc >= `DMBIA_GP_FIRST) && (loc <= `DMBIA_GP_LAST);
    // The offset only matters when isGp is set; other values are never stored.
    assign gpOffset = loc - `DMBIA_GP_FIRST;

    // Bank 0 general purpose RAM.
    dmbia_gp_ram gpRam
    (
        .sysClk(sysClk),
        .clkEn(clkEn),
        .wrEn(ramWr),
        .wrIndex(gpOffset[6:0]),
        .wrData(memWrData),
        .rdIndex(gpOffset[6:0]),
        .rdData(ramRdData)
    );

    // Next-state decode of reads and writes.
    always @*
    begin
        // By default all state holds and no strobe is raised.
        pointerZero_nxt = pointerZero_r;
        pointerOne_nxt = pointerOne_r;
        bankSelectBit_nxt = bankSelectBit_r;
        workRegister_nxt = workRegister_r;
        rdData_nxt = memRdData_r;
        ramWr = 1'b0;
        sfrRd_nxt = 1'b0;
        sfrWr_nxt = 1'b0;
        eeWr_nxt = 1'b0;
        // Reads pick the source of the registered read data.
        if (memRd)
        begin
            // A port aimed at a port wins over every other decode.
            if (portSelf)
            begin
                rdData_nxt = `DMBIA_NULL_DATA;
            end
            else if (isEeCtl)
            begin
                rdData_nxt = eepromControlRdData;
            end
            else if (isSfr)
            begin
                if (loc == `DMBIA_ADDR_PTR0)
                begin
                    rdData_nxt = pointerZero_r;
                end
                else if (loc == `DMBIA_ADDR_PTR1)
                begin
                    rdData_nxt = pointerOne_r;
                end
                else if (loc == `DMBIA_ADDR_BANKSEL)
                begin
                    rdData_nxt = {7'h00, bankSelectBit_r};
                end
                else if (loc == `DMBIA_ADDR_WORK)
                begin
                    rdData_nxt = workRegister_r;
                end
                // Remaining core locations are the ports, which are never storage.
                else if (isCore)
                begin
                    rdData_nxt = `DMBIA_NULL_DATA;
                end
                else
                begin
                    rdData_nxt = sfrRdData;
                    sfrRd_nxt = 1'b1;
                end
            end
            else if (isGp)
            begin
                rdData_nxt = ramRdData;
            end
            else
            begin
                rdData_nxt = `DMBIA_NULL_DATA;
            end
            // A load into the work register is how memory moves start.
            if (workLoad)
            begin
                workRegister_nxt = rdData_nxt;
            end
        end
        // Writes through a port aimed at a port are dropped.
        if (memWr && !portSelf)
        begin
            // Eeprom control exists only behind port one in bank 1.
            if (isEeCtl)
            begin
                eeWr_nxt = 1'b1;
            end
            else if (isSfr)
            begin
                if (loc == `DMBIA_ADDR_PTR0)
                begin
                    pointerZero_nxt = memWrData;
                end
                else if (loc == `DMBIA_ADDR_PTR1)
                begin
                    pointerOne_nxt = memWrData;
                end
                else if (loc == `DMBIA_ADDR_BANKSEL)
                begin
                    bankSelectBit_nxt = memWrData[`DMBIA_BANKSEL_BIT];
                end
                else if (loc == `DMBIA_ADDR_WORK)
                begin
                    workRegister_nxt = memWrData;
                end
                // Ports written directly never land here; the pointer redirects them.
                else if (!isCore)
                begin
                    sfrWr_nxt = 1'b1;
                end
            end
            else if (isGp)
            begin
                ramWr = 1'b1;
            end
        end
        // ALU results land in the work register and win over other loads.
        if (aluWr)
        begin
            workRegister_nxt = aluResult;
        end
    end

    // Bank select: cleared by every reset that reaches reset_n.
    // A watchdog time-out in power-down is delivered without reset_n, so the
    // selected bank survives it; the reset cause input is informative only.
    always @(posedge sysClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bankSelectBit_r <= `DMBIA_BANKSEL_RESET;
        end
        else if (clkEn)
        begin
            bankSelectBit_r <= bankSelectBit_nxt;
        end
    end

    // Pointers and work register: plain storage, cleared by the full reset.
    always @(posedge sysClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pointerZero_r <= `DMBIA_PTR_RESET;
            pointerOne_r <= `DMBIA_PTR_RESET;
            workRegister_r <= `DMBIA_WORK_RESET;
        end
        else if (clkEn)
        begin
            pointerZero_r <= pointerZero_nxt;
            pointerOne_r <= pointerOne_nxt;
            workRegister_r <= workRegister_nxt;
        end
    end

    // Read data holds between reads so a late consumer still sees it.
    always @(posedge sysClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            memRdData_r <= `DMBIA_NULL_DATA;
        end
        else if (clkEn)
        begin
            memRdData_r <= rdData_nxt;
        end
    end

    // External register strobes stand for one cycle.
    // Address and data are captured on every enabled cycle.
    always @(posedge sysClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sfrRd_r <= 1'b0;
            sfrWr_r <= 1'b0;
            sfrAddr_r <= 8'h00;
            sfrWrData_r <= 8'h00;
        end
        else if (clkEn)
        begin
            sfrRd_r <= sfrRd_nxt;
            sfrWr_r <= sfrWr_nxt;
            sfrAddr_r <= loc;
            sfrWrData_r <= memWrData;
        end
    end

    // Eeprom control strobe and the data it carries.
    always @(posedge sysClk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eepromControlWr_r <= 1'b0;
            eepromControlWrData_r <= 8'h00;
        end
        else if (clkEn)
        begin
            eepromControlWr_r <= eeWr_nxt;
            eepromControlWrData_r <= memWrData;
        end
    end

endmodule // dmbia_core
`default_nettype wire

// >>> rtl/dmbia_defs.vh
// Address map, field positions and sizes of the data memory addressing block.
`ifndef DMBIA_DEFS_VH
`define DMBIA_DEFS_VH

`define DMBIA_ADDR_PORT0 8'h00
`define DMBIA_ADDR_PTR0 8'h01
`define DMBIA_ADDR_PORT1 8'h02
`define DMBIA_ADDR_PTR1 8'h03
`define DMBIA_ADDR_BANKSEL 8'h04
`define DMBIA_ADDR_WORK 8'h05
`define DMBIA_ADDR_EECTL 8'h40
`define DMBIA_SFR_LAST 8'h3f
`define DMBIA_GP_FIRST 8'h40
`define DMBIA_GP_LAST 8'h9f
`define DMBIA_BANKSEL_BIT 0
`define DMBIA_BANKSEL_RESET 1'b0
`define DMBIA_PTR_RESET 8'h00
`define DMBIA_WORK_RESET 8'h00
`define DMBIA_NULL_DATA 8'h00
`define DMBIA_GP_WORDS 96

`endif

// >>> rtl/dmbia_gp_ram.v
// General purpose RAM of bank 0: one word array, synchronous write, combinational read.
`timescale 1ns/1ns
`default_nettype none
`include "dmbia_defs.vh"

module dmbia_gp_ram
(
    // Clock.
    input wire sysClk,
    input wire clkEn,
    // Write side.
    input wire wrEn,
    input wire [6:0] wrIndex,
    input wire [7:0] wrData,
    // Read side.
    input wire [6:0] rdIndex,
    output wire [7:0] rdData
);

    reg [7:0] mem [0:`DMBIA_GP_WORDS-1];

    // Store a word when enabled; contents are not reset, as in real RAM.
    always @(posedge sysClk)
    begin
        if (clkEn && wrEn)
        begin
            mem[wrIndex] <= wrData;
        end
    end

    assign rdData = mem[rdIndex];

endmodule // dmbia_gp_ram
`default_nettype wire

// >>> tb/dmbia_monitor.sv
// Port checker of the data memory addressing core.
`timescale 1ns/1ns
`default_nettype none
module dmbia_monitor
(
    // Clock and reset.
    input wire logic sysClk,
    input wire logic reset_n,
    // Requests.
    input wire logic clkEn,
    input wire logic memRd,
    input wire logic memWr,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] memWrData,
    input wire logic aluWr,
    input wire logic [7:0] aluResult,
    // Results.
    input wire logic [7:0] memRdData_r,
    input wire logic sfrRd_r,
    input wire logic sfrWr_r,
    input wire logic [7:0] sfrAddr_r,
    input wire logic [7:0] sfrWrData_r,
    input wire logic eepromControlWr_r,
    input wire logic [7:0] workRegister_r,
    input wire logic bankSelectBit_r
);
    default clocking cb @(posedge sysClk); endclocking
    default disable iff (!reset_n);
    // Accepted requests.
    wire logic rdOk = clkEn && memRd;
    wire logic wrOk = clkEn && memWr;
    wire logic bankWr = wrOk && memAddr == 8'h04;
    reset_clear_a: assert property (!$past(reset_n) |-> !bankSelectBit_r)
        else $error("bank not clear after reset");
    bank_write_a: assert property (bankWr |=> bankSelectBit_r == $past(memWrData[0]))
        else $error("bank bit not taken from bit 0");
    bank_hold_a: assert property (!bankWr |=> $stable(bankSelectBit_r))
        else $error("bank bit changed without write");
    alu_work_a: assert property (clkEn && aluWr |=> workRegister_r == $past(aluResult))
        else $error("alu result not in work register");
    bank_read_a: assert property (rdOk && memAddr == 8'h04
        |=> memRdData_r == {7'h00, $past(bankSelectBit_r)})
        else $error("bank select read wrong");
    work_read_a: assert property (rdOk && memAddr == 8'h05
        |=> memRdData_r == $past(workRegister_r))
        else $error("work register read wrong");
    direct_eec_a: assert property (wrOk && memAddr == 8'h40 |=> !eepromControlWr_r)
        else $error("direct write reached eeprom control");
    sfr_write_a: assert property (wrOk && memAddr inside {[8'h06:8'h3f]}
        |=> sfrWr_r && sfrAddr_r == $past(memAddr) && sfrWrData_r == $past(memWrData))
        else $error("shared register write not forwarded");
    sfr_read_a: assert property (rdOk && memAddr inside {[8'h06:8'h3f]} |=> sfrRd_r)
        else $error("shared register read not flagged");
endmodule // dmbia_monitor
bind dmbia_core dmbia_monitor dmbia_monitor_i (.sysClk(sysClk), .reset_n(reset_n),
    .clkEn(clkEn), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
    .memWrData(memWrData), .aluWr(aluWr), .aluResult(aluResult),
    .memRdData_r(memRdData_r), .sfrRd_r(sfrRd_r), .sfrWr_r(sfrWr_r), .sfrAddr_r(sfrAddr_r),
    .sfrWrData_r(sfrWrData_r), .eepromControlWr_r(eepromControlWr_r),
    .workRegister_r(workRegister_r), .bankSelectBit_r(bankSelectBit_r));
`default_nettype wire

// >>> tb/dmbia_sfr_model.sv
// Model of the external special function registers and eeprom control.
`timescale 1ns/1ns
`default_nettype none
module dmbia_sfr_model
(
    // Clock.
    input wire logic sysClk,
    // Core side.
    input wire logic [7:0] memAddr,
    input wire logic sfrWr_r,
    input wire logic [7:0] sfrAddr_r,
    input wire logic [7:0] sfrWrData_r,
    input wire logic eepromControlWr_r,
    input wire logic [7:0] eepromControlWrData_r,
    output logic [7:0] sfrRdData,
    output logic [7:0] eepromControlRdData
);
    logic [7:0] regs [0:63];
    // Strobed writes land one cycle after the core takes them.
    always @(posedge sysClk)
    begin
        if (sfrWr_r)
            regs[sfrAddr_r[5:0]] <= sfrWrData_r;
        if (eepromControlWr_r)
            eepromControlRdData <= eepromControlWrData_r;
    end
    // Reads follow the address the datapath presents.
    assign sfrRdData = regs[memAddr[5:0]];
endmodule // dmbia_sfr_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench of the data memory addressing core.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic sysClk = 1'b0;
    logic reset_n = 1'b0;
    logic memRd = 1'b0, memWr = 1'b0, aluWr = 1'b0, workLoad = 1'b0;
    logic [7:0] memAddr = 8'h00, memWrData = 8'h00, aluResult = 8'h00;
    logic [7:0] sfrRd, eeRd, rdData, sfrAddr, sfrWd, eeWd, work, seed, a, d;
    logic sfrWr, eeWr, bank, sfrRdStrobe;
    logic clkEnable = 1'b1, watchdogPdReset = 1'b0;
    int failures = 0, checks_done = 0;
    always #5 sysClk = ~sysClk;
    dmbia_core dmbia_core_i (.sysClk(sysClk), .clkEn(clkEnable), .reset_n(reset_n),
        .watchdogPowerDownReset(watchdogPdReset), .memRd(memRd), .memWr(memWr),
        .memAddr(memAddr), .memWrData(memWrData), .memRdData_r(rdData), .aluWr(aluWr),
        .aluResult(aluResult), .workLoad(workLoad), .sfrRdData(sfrRd),
        .sfrRd_r(sfrRdStrobe),
        .sfrWr_r(sfrWr), .sfrAddr_r(sfrAddr), .sfrWrData_r(sfrWd),
        .eepromControlRdData(eeRd), .eepromControlWr_r(eeWr),
        .eepromControlWrData_r(eeWd), .workRegister_r(work), .bankSelectBit_r(bank));
    dmbia_sfr_model dmbia_sfr_model_i (.sysClk(sysClk), .memAddr(memAddr),
        .sfrWr_r(sfrWr), .sfrAddr_r(sfrAddr), .sfrWrData_r(sfrWd),
        .eepromControlWr_r(eeWr), .eepromControlWrData_r(eeWd),
        .sfrRdData(sfrRd), .eepromControlRdData(eeRd));
    // Next value of the stimulus shift register.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // One request, launched at the falling edge.
    task automatic op(input logic r, w, input logic [7:0] ad, dt);
        @(negedge sysClk);
        memRd = r;
        memWr = w;
        memAddr = ad;
        memWrData = dt;
    endtask
    task automatic wr(input logic [7:0] ad, dt);
        op(1'b0, 1'b1, ad, dt);
    endtask
    // Compare one result with its expected value and count it.
    task automatic check(input string what, input logic [7:0] e, s);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, s);
        end
    endtask
    // Read and compare the registered data after the taking edge.
    task automatic rd(input logic [7:0] ad, e);
        op(1'b1, 1'b0, ad, 8'h00);
        @(posedge sysClk);
        #1;
        check("memRdData_r", e, rdData);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog against a hung run.
    initial
    begin
        #50000;
        failures++;
        tally_and_finish();
    end
    // Main sequence.
    initial
    begin
        seed = 8'h03;
        repeat (2) @(negedge sysClk);
        reset_n = 1'b1;
        rd(8'h04, 8'h00);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h01);
        wr(8'h04, 8'hfe);
        rd(8'h04, 8'h00);
        // Random locations through the direct path and both ports.
        repeat (20)
        begin
            seed = lfsr(seed);
            a = 8'h41 + seed % 8'd95;
            seed = lfsr(seed);
            d = seed;
            wr(a, d);
            wr(8'h01, a);
            rd(8'h01, a);
            rd(8'h00, d);
            wr(8'h03, a);
            rd(8'h02, d);
            wr(8'h04, 8'h01);
            rd(a, d);
            rd(8'h00, d);
            rd(8'h02, 8'h00);
            wr(8'h02, ~d);
            wr(8'h04, 8'h00);
            rd(a, d);
        end
        // Pointers aimed at the ports themselves.
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h5a);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        wr(8'h03, 8'h02);
        wr(8'h02, 8'ha5);
        rd(8'h02, 8'h00);
        // A write while the clock enable is low leaves the pointer alone.
        op(1'b0, 1'b1, 8'h01, 8'h77);
        clkEnable = 1'b0;
        op(1'b0, 1'b0, 8'h00, 8'h00);
        clkEnable = 1'b1;
        rd(8'h01, 8'h00);
        // Shared registers written in bank 1, read in bank 0.
        repeat (4)
        begin
            seed = lfsr(seed);
            a = 8'h06 + seed % 8'd58;
            wr(8'h04, 8'h01);
            wr(a, seed);
            wr(8'h04, 8'h00);
            rd(a, seed);
            check("sfrRd_r", 8'h01, {7'h00, sfrRdStrobe});
        end
        // Eeprom control through port one in bank 1; direct 40H stays RAM.
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h40);
        wr(8'h02, 8'h3c);
        rd(8'h04, 8'h01);
        rd(8'h02, 8'h3c);
        wr(8'h40, 8'hc3);
        rd(8'h40, 8'hc3);
        // ALU result and a move through the work register.
        @(negedge sysClk);
        aluWr = 1'b1;
        aluResult = seed;
        @(negedge sysClk);
        aluWr = 1'b0;
        rd(8'h05, seed);
        @(negedge sysClk);
        workLoad = 1'b1;
        rd(8'h40, 8'hc3);
        check("workRegister_r", 8'hc3, work);
        @(negedge sysClk);
        workLoad = 1'b0;
        wr(8'h9f, work);
        rd(8'h9f, 8'hc3);
        // A watchdog time-out in power-down keeps bank 1; a real reset clears it.
        wr(8'h04, 8'h01);
        op(1'b0, 1'b0, 8'h00, 8'h00);
        watchdogPdReset = 1'b1;
        rd(8'h04, 8'h01);
        @(negedge sysClk);
        watchdogPdReset = 1'b0;
        reset_n = 1'b0;
        @(negedge sysClk);
        reset_n = 1'b1;
        rd(8'h04, 8'h00);
        check("bankSelectBit_r", 8'h00, {7'h00, bank});
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
